// ---- src/dsf_pkg.sv ----
// dsf_pkg: constants, states and carriers of the start/stop and fault supervisor
// assumes a 100 MHz system clock; all pins are synchronised inside the block
package dsf_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam longint CLK_HZ      = 100_000_000;
    localparam longint SETTLE_MS   = 1000;
    localparam longint RETARD_MS   = 100;
    localparam longint INVERSE_TIME_TRIP_MIN_S  = 15;
    localparam longint INVERSE_TIME_TRIP_MAX_S  = 60;
    localparam longint SETTLE_CYC  = SETTLE_MS * CLK_HZ / 1000;
    localparam longint RETARD_CYC  = RETARD_MS * CLK_HZ / 1000;
    localparam longint INVERSE_TIME_TRIP_MAX_CYC = INVERSE_TIME_TRIP_MAX_S * CLK_HZ;
    // full-scale ramp is 65536 steps; ticks per second of ramp time
    localparam longint RAMP_TICK_PER_S = CLK_HZ / 65536;
    localparam logic [7:0] RAMP_MIN_S = 8'h05;
    localparam logic [7:0] RAMP_MAX_S = 8'h32;

    // ****************************************
    // levels
    // ****************************************
    localparam logic [8:0]  INVERSE_TIME_TRIP_TRIP_PCT = 9'h0AF;
    localparam logic [8:0]  INVERSE_TIME_TRIP_SEG1_PCT = 9'h07D;
    localparam logic [8:0]  INVERSE_TIME_TRIP_SEG2_PCT = 9'h096;
    localparam logic [15:0] MIN_REF       = 16'h0A00;
    localparam logic [15:0] NCO_GAIN      = 16'h0010;
    localparam logic [15:0] LOCK_WIN      = 16'h0064;
    localparam logic [3:0]  LOCK_N        = 4'h8;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0]  OFF_RAMP   = 4'h0;
    localparam logic [3:0]  OFF_STATUS = 4'h4;
    localparam logic [3:0]  OFF_REF    = 4'h8;
    localparam logic [15:0] RAMP_RST   = 16'h0A0A;
    localparam int          RAMP_ACC_LSB = 0;
    localparam int          RAMP_DEC_LSB = 8;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RUN  = 4'b0010,
        ST_STOP = 4'b0100,
        ST_TRIP = 4'b1000
    } dsf_state_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic hold_minimum_speed;
        logic external_fault_clear;
        logic sync_request;
        logic ext_freq;
        logic phase_fault;
        logic link_overvoltage;
        logic current_limit;
        logic linear_override;
        logic slowdown_override;
        logic low_voltage;
    } dsf_pins_t;

    typedef struct packed {
        logic running_readout;
        logic at_minimum_readout;
        logic fault_trip_readout;
        logic locked_readout;
        logic low_gain_request_n;
        logic freq_lamp;
        logic lock_lamp;
        logic inverse_time_trip_lamp;
        logic phase_loss_lamp;
        logic link_overvoltage_lamp;
        logic pulse6;
        logic freq_raise;
        logic freq_lower;
        logic firing_retard;
        logic firing_lockout;
        logic firing_enable;
    } dsf_out_t;

endpackage

// ---- src/dsf_supervisor.sv ----
// dsf_supervisor: start/stop sequencing, ramp, pulse train, sync and fault shutdown
// assumes pins arrive asynchronously and a plain register port on clock_i
//
// Function
// - start begins at minimum frequency and voltage, then ramps to reference
// - stop ramps down at decel rate until low voltage, then stops
// - hold input drops to minimum frequency; release re-accelerates at set rate
// - at-minimum readout when minimum voltage and minimum frequency both seen
// - running readout shows inverter operating or stopped
// - indicator lamp blinks at a rate following inverter frequency
// - any fault shutdown asserts fault trip readout
// - completed normal stop clears fault latches and lamps
// - external fault clear input also clears fault latches
// - current above trip threshold trips at once with inverse-time lamp
// - under current limit, trip after 15 s to 1 min, shorter when higher (code: 20 s to 60 s; trip level trips at once)
// - sync request makes inverter frequency follow external frequency
// - frequency compare issues raise/lower corrections to oscillator
// - phase and frequency lock lights lock lamp and locked readout
// - active-low low gain on limit, overrides, unsynchronised or not started
// - separate accel and decel times, 5 to 50 s full scale
// - pulse train at six times fundamental frequency
// - phase loss or wrong sequence lights lamp, inhibits drive
// - link overvoltage lights lamp and shuts down at once
// - fault first retards converter firing fully at once
// - about 0.1 s later all converter firing locked out
// - firing withheld after energisation until control settles
// - firing supply on about 1 s after power applied
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module dsf_supervisor
    import dsf_pkg::*;
#(
    parameter logic [31:0] SETTLE_CYCLES = 32'(dsf_pkg::SETTLE_CYC),
    parameter logic [31:0] RETARD_CYCLES = 32'(dsf_pkg::RETARD_CYC),
    parameter logic [39:0] INVERSE_TIME_TRIP_CYCLES   = 40'(dsf_pkg::INVERSE_TIME_TRIP_MAX_CYC),
    parameter logic [16:0] RAMP_TICK     = 17'(dsf_pkg::RAMP_TICK_PER_S)
) (
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire dsf_pkg::dsf_pins_t pins_i,
    input  wire logic [15:0]       reference_i,
    input  wire logic [8:0]        current_pct_i,
    input  wire logic [3:0]        addr_i,
    input  wire logic [31:0]       wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic [31:0]            rdata_o,
    output logic [15:0]            ramped_reference_o,
    output dsf_pkg::dsf_out_t      out_o
);
    import dsf_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    dsf_pins_t   pin_m, pin_s;
    logic [15:0] ref_m, ref_s;
    logic [8:0]  pct_m, pct_s;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pin_m <= '0;
            pin_s <= '0;
            ref_m <= '0;
            ref_s <= '0;
            pct_m <= '0;
            pct_s <= '0;
        end else if (ce_i) begin
            pin_m <= pins_i;
            pin_s <= pin_m;
            ref_m <= reference_i;
            ref_s <= ref_m;
            pct_m <= current_pct_i;
            pct_s <= pct_m;
        end
    end

    // ****************************************
    // register port
    // ****************************************
    logic [15:0] ramp_cfg_q;
    logic [31:0] rdata_q;
    dsf_state_t  st_q, st_d;
    logic        inverse_time_trip_q, ploss_q, lov_q, locked_q;
    logic [15:0] ramped_q;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ramp_cfg_q <= RAMP_RST;
        end else if (ce_i && wr_i && addr_i == OFF_RAMP) begin
            ramp_cfg_q <= wdata_i[15:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else if (ce_i) begin
            rdata_q <= '0;
            if (rd_i) begin
                case (addr_i)
                    OFF_RAMP:   rdata_q <= {16'h0000, ramp_cfg_q};
                    OFF_STATUS: rdata_q <= {24'h00_0000, locked_q, lov_q, ploss_q, inverse_time_trip_q, st_q};
                    OFF_REF:    rdata_q <= {16'h0000, ramped_q};
                    default:    rdata_q <= '0;
                endcase
            end
        end
    end

    // ramp times clamped into the settable span
    function automatic logic [7:0] clamp_s(input logic [7:0] s);
        clamp_s = (s < RAMP_MIN_S) ? RAMP_MIN_S : ((s > RAMP_MAX_S) ? RAMP_MAX_S : s);
    endfunction

    // ****************************************
    // fault latches
    // ****************************************
    logic        fault_any, stop_done, fault_clr, inverse_time_trip_set, oc_fast;
    logic [39:0] inverse_time_trip_acc_q;
    logic [4:0]  inverse_time_trip_inc;
    logic        settled_q;

    assign fault_any = inverse_time_trip_q | ploss_q | lov_q;
    assign stop_done = (st_q == ST_STOP) && pin_s.low_voltage;
    assign fault_clr = stop_done | pin_s.external_fault_clear | ((st_q == ST_TRIP) && pin_s.stop);
    assign oc_fast   = pct_s >= INVERSE_TIME_TRIP_TRIP_PCT;
    assign inverse_time_trip_inc  = (pct_s >= INVERSE_TIME_TRIP_SEG2_PCT) ? 5'h0C : ((pct_s >= INVERSE_TIME_TRIP_SEG1_PCT) ? 5'h08 : 5'h04);
    assign inverse_time_trip_set  = (st_q == ST_RUN || st_q == ST_STOP) &&
                       (oc_fast || inverse_time_trip_acc_q >= {INVERSE_TIME_TRIP_CYCLES[37:0], 2'b00});

    // inverse time: weight 4..12 per cycle gives 60 s down to 20 s; weight 16 only at trip level, which trips at once
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            inverse_time_trip_acc_q <= '0;
        end else if (ce_i) begin
            if (pin_s.current_limit && st_q != ST_IDLE && st_q != ST_TRIP) begin
                inverse_time_trip_acc_q <= inverse_time_trip_acc_q + 40'(oc_fast ? 5'h10 : inverse_time_trip_inc);
            end else begin
                inverse_time_trip_acc_q <= '0;
            end
        end
    end

    // set wins over clear
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            inverse_time_trip_q  <= 1'b0;
            ploss_q <= 1'b0;
            lov_q   <= 1'b0;
        end else if (ce_i) begin
            inverse_time_trip_q  <= inverse_time_trip_set | (inverse_time_trip_q & ~fault_clr);
            ploss_q <= pin_s.phase_fault | (ploss_q & ~fault_clr);
            lov_q   <= pin_s.link_overvoltage | (lov_q & ~fault_clr);
        end
    end

    // ****************************************
    // start/stop sequencer
    // ****************************************
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (pin_s.start && !pin_s.stop && !fault_any && settled_q) begin
                    st_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (fault_any) begin
                    st_d = ST_TRIP;
                end else if (pin_s.stop) begin
                    st_d = ST_STOP;
                end
            end
            ST_STOP: begin
                if (fault_any) begin
                    st_d = ST_TRIP;
                end else if (pin_s.low_voltage) begin
                    st_d = ST_IDLE;
                end
            end
            ST_TRIP: begin
                if (!fault_any) begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // timed ramp
    // ****************************************
    logic [15:0] target;
    logic [19:0] rate_cnt_q, rate_lim;
    logic        up;

    always_comb begin
        target = 16'h0000;
        if (st_q == ST_RUN) begin
            if (pin_s.hold_minimum_speed || ref_s < MIN_REF) begin
                target = MIN_REF;
            end else begin
                target = ref_s;
            end
        end
    end

    assign up       = ramped_q < target;
    assign rate_lim = 20'(up ? clamp_s(ramp_cfg_q[RAMP_ACC_LSB +: 8]) * RAMP_TICK
                             : clamp_s(ramp_cfg_q[RAMP_DEC_LSB +: 8]) * RAMP_TICK);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rate_cnt_q <= '0;
            ramped_q   <= '0;
        end else if (ce_i) begin
            if (st_q == ST_IDLE && st_d == ST_RUN) begin
                ramped_q   <= MIN_REF;
                rate_cnt_q <= '0;
            end else if (st_q == ST_RUN || st_q == ST_STOP) begin
                if (ramped_q == target || rate_cnt_q + 20'h0_0001 >= rate_lim) begin
                    rate_cnt_q <= '0;
                    if (ramped_q != target) begin
                        ramped_q <= up ? ramped_q + 16'h0001 : ramped_q - 16'h0001;
                    end
                end else begin
                    rate_cnt_q <= rate_cnt_q + 20'h0_0001;
                end
            end else begin
                ramped_q   <= '0;
                rate_cnt_q <= '0;
            end
        end
    end

    // ****************************************
    // frequency generator and discriminator
    // ****************************************
    logic [31:0] nco_q, nco_inc;
    logic [32:0] nco_sum;
    logic        p6_q, ext_d_q, raise_q, lower_q, fund_edge, ext_edge, blink_q;
    logic [2:0]  sixth_q;
    logic [15:0] err_q;
    logic [3:0]  lock_cnt_q;
    logic        sync_on;

    assign sync_on  = pin_s.sync_request && st_q == ST_RUN;
    assign nco_inc  = ramped_q * NCO_GAIN
                    + ((sync_on && raise_q) ? 32'({ramped_q, 4'h0}) : 32'h0000_0000)
                    - ((sync_on && lower_q) ? 32'({4'h0, ramped_q[15:4]}) : 32'h0000_0000);
    assign nco_sum  = {1'b0, nco_q} + {1'b0, nco_inc};
    assign fund_edge = p6_q && sixth_q == 3'h5;
    assign ext_edge  = pin_s.ext_freq && !ext_d_q;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            nco_q   <= '0;
            p6_q    <= 1'b0;
            sixth_q <= '0;
            blink_q <= 1'b0;
        end else if (ce_i) begin
            nco_q <= nco_sum[31:0];
            p6_q  <= nco_sum[32] && (st_q == ST_RUN || st_q == ST_STOP);
            if (p6_q) begin
                sixth_q <= (sixth_q == 3'h5) ? 3'h0 : sixth_q + 3'h1;
                if (sixth_q == 3'h5) begin
                    blink_q <= ~blink_q;
                end
            end
        end
    end

    // raise when the outside edge leads, lower when ours leads
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ext_d_q <= 1'b0;
            raise_q <= 1'b0;
            lower_q <= 1'b0;
        end else if (ce_i) begin
            ext_d_q <= pin_s.ext_freq;
            if (!sync_on || ((raise_q || ext_edge) && (lower_q || fund_edge))) begin
                raise_q <= 1'b0;
                lower_q <= 1'b0;
            end else begin
                raise_q <= raise_q | ext_edge;
                lower_q <= lower_q | fund_edge;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            err_q      <= '0;
            lock_cnt_q <= '0;
            locked_q   <= 1'b0;
        end else if (ce_i) begin
            if (!sync_on) begin
                err_q      <= '0;
                lock_cnt_q <= '0;
            end else if (ext_edge) begin
                err_q <= '0;
                if (err_q > LOCK_WIN) begin
                    lock_cnt_q <= '0;
                end else if (lock_cnt_q != LOCK_N) begin
                    lock_cnt_q <= lock_cnt_q + 4'h1;
                end
            end else if ((raise_q ^ lower_q) && err_q != 16'hFFFF) begin
                err_q <= err_q + 16'h0001;
            end
            locked_q <= sync_on && lock_cnt_q == LOCK_N;
        end
    end

    // ****************************************
    // converter firing control
    // ****************************************
    logic [31:0] settle_cnt_q, ret_cnt_q;
    logic        retard_q, lockout_q;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            settle_cnt_q <= '0;
            settled_q    <= 1'b0;
        end else if (ce_i && !settled_q) begin
            settle_cnt_q <= settle_cnt_q + 32'h0000_0001;
            settled_q    <= settle_cnt_q + 32'h0000_0001 >= SETTLE_CYCLES;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            retard_q  <= 1'b0;
            lockout_q <= 1'b0;
            ret_cnt_q <= '0;
        end else if (ce_i) begin
            retard_q <= fault_any;
            if (!fault_any) begin
                ret_cnt_q <= '0;
                lockout_q <= 1'b0;
            end else if (retard_q && !lockout_q) begin
                ret_cnt_q <= ret_cnt_q + 32'h0000_0001;
                lockout_q <= ret_cnt_q + 32'h0000_0001 >= RETARD_CYCLES;
            end
        end
    end

    // ****************************************
    // readouts and lamps
    // ****************************************
    logic atmin;
    assign atmin = pin_s.low_voltage && ramped_q <= MIN_REF && st_q != ST_IDLE;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            out_o              <= '0;
            out_o.firing_lockout <= 1'b1;
            ramped_reference_o <= '0;
        end else if (ce_i) begin
            out_o.running_readout    <= st_q == ST_RUN || st_q == ST_STOP;
            out_o.at_minimum_readout <= atmin;
            out_o.fault_trip_readout <= fault_any;
            out_o.locked_readout     <= locked_q;
            out_o.lock_lamp          <= locked_q;
            out_o.low_gain_request_n <= !(pin_s.current_limit || pin_s.linear_override ||
                                          pin_s.slowdown_override || !locked_q ||
                                          st_q != ST_RUN);
            out_o.freq_lamp              <= blink_q;
            out_o.inverse_time_trip_lamp <= inverse_time_trip_q;
            out_o.phase_loss_lamp        <= ploss_q;
            out_o.link_overvoltage_lamp  <= lov_q;
            out_o.pulse6                 <= p6_q;
            out_o.freq_raise             <= raise_q;
            out_o.freq_lower             <= lower_q;
            out_o.firing_retard          <= retard_q;
            out_o.firing_lockout         <= lockout_q || !settled_q;
            out_o.firing_enable          <= settled_q && !lockout_q && !ploss_q;
            ramped_reference_o           <= ramped_q;
        end
    end

    assign rdata_o = rdata_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_start_taken;
        ce_i && st_q == ST_IDLE && st_d == ST_RUN;
    endsequence
    sequence s_lock_rise;
        $rose(lockout_q);
    endsequence

    AST_START_MIN: assert property (s_start_taken |=> st_q == ST_RUN && ramped_q == MIN_REF)
        else $error("start did not begin at minimum");
    AST_STOP_DONE: assert property (ce_i && st_q == ST_STOP && pin_s.low_voltage && !fault_any
        |=> st_q == ST_IDLE ##1 (!out_o.running_readout || !$past(ce_i)))
        else $error("stop did not end at low voltage");
    AST_HOLD_MIN: assert property (ce_i && st_q == ST_RUN && pin_s.hold_minimum_speed
        && ramped_q == MIN_REF && !fault_any && !pin_s.stop |=> ramped_q == MIN_REF)
        else $error("hold left minimum frequency");
    AST_AT_MIN: assert property (ce_i |=> out_o.at_minimum_readout == $past(atmin))
        else $error("at-minimum readout wrong");
    AST_FAULT_READOUT: assert property (ce_i && fault_any |=> out_o.fault_trip_readout)
        else $error("fault trip readout missing");
    AST_EXT_CLEAR: assert property (ce_i && pin_s.external_fault_clear && !pin_s.phase_fault
        |=> !ploss_q)
        else $error("external clear did not clear latch");
    AST_FAST_TRIP: assert property (ce_i && oc_fast && st_q == ST_RUN
        |=> inverse_time_trip_q ##1 (!ce_i || out_o.inverse_time_trip_lamp))
        else $error("overcurrent did not trip");
    AST_LOW_GAIN: assert property (ce_i && pin_s.current_limit |=> !out_o.low_gain_request_n)
        else $error("low gain not requested");
    AST_RETARD: assert property (ce_i && $rose(fault_any) |=> retard_q && !lockout_q)
        else $error("retard did not precede lockout");
    AST_LOCKOUT: assert property (s_lock_rise |-> retard_q && $past(ret_cnt_q) + 32'h0000_0001
        >= RETARD_CYCLES)
        else $error("lockout came early");
    AST_SETTLE: assert property (out_o.firing_enable |-> settled_q)
        else $error("firing before settling");
    AST_NO_START: assert property (ce_i && st_q == ST_IDLE && fault_any |=> st_q == ST_IDLE)
        else $error("start taken with fault latched");

endmodule

`default_nettype wire

// ---- verif/dsf_ctrl_model.sv ----
// dsf_ctrl_model: system control side feedback for the supervisor bench
// assumes link voltage follows the ramped reference
`timescale 1ns/1ps
`default_nettype none
module dsf_ctrl_model (
    input  wire logic        clock_i,
    input  wire logic [15:0] ramped_i,
    output logic             low_voltage_o
);
    import dsf_pkg::*;
    // minimum voltage seen once ramp sits at the floor
    always_ff @(posedge clock_i) begin
        low_voltage_o <= (ramped_i <= MIN_REF);
    end
endmodule
`default_nettype wire

// ---- verif/dsf_supervisor_tb.sv ----
// dsf_supervisor_tb: directed sequences over pins and register port
// assumes shortened timing parameters and the bench control model
`timescale 1ns/1ps
`default_nettype none
module dsf_supervisor_tb;
    import dsf_pkg::*;
    logic        clock_i, rst_i, wr_i, rd_i, lv;
    logic [3:0]  addr_i;
    logic [31:0] wdata_i, rdata_o, rv;
    logic [15:0] reference_i, ramped;
    logic [8:0]  pct;
    logic [2:0]  lamps;
    dsf_pins_t   p, pins;
    dsf_out_t    o;
    int          miscompares, tests_run, cyc, n;

    always_comb begin
        pins = p;
        pins.low_voltage = lv;
    end
    assign lamps = {o.link_overvoltage_lamp, o.phase_loss_lamp, o.inverse_time_trip_lamp};

    dsf_supervisor #(.SETTLE_CYCLES(32'h0000_0064), .RETARD_CYCLES(32'h0000_0014),
        .INVERSE_TIME_TRIP_CYCLES(40'h00_0000_0190), .RAMP_TICK(17'h0_0001)) dut (
        .clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .pins_i(pins),
        .reference_i(reference_i), .current_pct_i(pct), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .ramped_reference_o(ramped), .out_o(o));
    dsf_ctrl_model model (.clock_i(clock_i), .ramped_i(ramped), .low_voltage_o(lv));

    // ****************************************
    // clock, timeout, tasks
    // ****************************************
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("checks %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 rv = rdata_o;
    endtask
    task automatic wait_ramp(input logic [15:0] t, input int lim);
        n = 0;
        while (ramped !== t && n < lim) begin
            tick(1);
            n++;
        end
        chk(32'(ramped), 32'(t));
    endtask

    // ****************************************
    // sequences
    // ****************************************
    initial begin
        miscompares = 0;
        tests_run = 0;
        cyc = 0;
        rst_i = 1'b1;
        p = '0;
        reference_i = 16'h0A40;
        pct = 9'h000;
        addr_i = 4'h0;
        wdata_i = 32'h0000_0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        tick(2);
        chk(32'(o.firing_lockout), 32'h0000_0001);
        rst_i <= 1'b0;
        rd(OFF_RAMP);
        chk(rv, 32'h0000_0A0A);
        rd(OFF_STATUS);
        chk(rv, 32'h0000_0001);
        rd(4'hC);
        chk(rv, 32'h0000_0000);
        wr(OFF_RAMP, 32'hFFFF_0101);
        rd(OFF_RAMP);
        chk(rv, 32'h0000_0101);
        p.start <= 1'b1;
        tick(8);
        p.start <= 1'b0;
        chk(32'(o.running_readout), 32'h0000_0000);
        chk(32'(o.firing_enable), 32'h0000_0000);
        tick(100);
        $display("test registers and settle done");
        @(posedge clock_i);
        p.start <= 1'b1;
        tick(6);
        p.start <= 1'b0;
        chk(32'(o.running_readout), 32'h0000_0001);
        chk(32'(ramped >= MIN_REF && ramped <= MIN_REF + 16'h0002), 32'h0000_0001);
        tick(240);
        chk(32'(ramped < 16'h0A40), 32'h0000_0001);
        wait_ramp(16'h0A40, 200);
        rd(OFF_REF);
        chk(rv, 32'h0000_0A40);
        chk(32'(o.low_gain_request_n), 32'h0000_0000);
        chk(32'(o.locked_readout), 32'h0000_0000);
        chk(32'(o.firing_enable), 32'h0000_0001);
        p.hold_minimum_speed <= 1'b1;
        wait_ramp(MIN_REF, 450);
        tick(4);
        chk(32'(o.at_minimum_readout), 32'h0000_0001);
        chk(32'(o.running_readout), 32'h0000_0001);
        p.hold_minimum_speed <= 1'b0;
        tick(14);
        chk(32'(o.at_minimum_readout), 32'h0000_0000);
        wait_ramp(16'h0A40, 400);
        p.stop <= 1'b1;
        wait_ramp(MIN_REF, 450);
        tick(8);
        p.stop <= 1'b0;
        chk(32'(o.running_readout), 32'h0000_0000);
        rd(OFF_STATUS);
        chk(rv, 32'h0000_0001);
        $display("test ramp hold stop done");
        for (int k = 0; k < 4; k++) begin
            rst_i <= 1'b1;
            tick(1);
            rst_i <= 1'b0;
            tick(105);
            p.start <= 1'b1;
            tick(8);
            p.start <= 1'b0;
            case (k)
                0: p.link_overvoltage <= 1'b1;
                1: p.phase_fault <= 1'b1;
                2: pct <= 9'h0AF;
                default: begin
                    p.current_limit <= 1'b1;
                    pct <= 9'h064;
                    tick(300);
                    chk(32'(o.fault_trip_readout), 32'h0000_0000);
                end
            endcase
            n = 0;
            while (o.firing_retard !== 1'b1 && n < 200) begin
                tick(1);
                n++;
            end
            chk(32'(n < ((k == 3) ? 130 : 8)), 32'h0000_0001);
            chk(32'(o.fault_trip_readout), 32'h0000_0001);
            chk(32'(lamps), (k == 0) ? 32'h4 : (k == 1) ? 32'h2 : 32'h1);
            n = 0;
            while (o.firing_lockout !== 1'b1 && n < 40) begin
                tick(1);
                n++;
            end
            chk(32'(n >= 18 && n <= 22), 32'h0000_0001);
            p <= '0;
            pct <= 9'h000;
            tick(1);
            p.start <= 1'b1;
            tick(8);
            rd(OFF_STATUS);
            chk(32'(rv[3:0]), 32'h0000_0008);
            p.start <= 1'b0;
            if (k % 2 == 0)
                p.external_fault_clear <= 1'b1;
            else
                p.stop <= 1'b1;
            tick(6);
            p <= '0;
            tick(4);
            chk(32'(o.fault_trip_readout), 32'h0000_0000);
            chk(32'(lamps), 32'h0000_0000);
            $display("test fault kind %0d done", k);
        end
        stop_test();
    end
endmodule
`default_nettype wire
